// >>> core/pnlc_regs.svh
// Register offsets, field positions, factory values and timing figures of the panel control.
`ifndef PNLC_REGS_SVH
`define PNLC_REGS_SVH
`define PNLC_A_STATUS 8'h00
`define PNLC_A_CTRL 8'h04
`define PNLC_A_VSET0 8'h08
`define PNLC_A_VSET1 8'h0c
`define PNLC_A_VSET2 8'h10
`define PNLC_A_SRE 8'h14
`define PNLC_A_CFG 8'h18
`define PNLC_C_REM 0
`define PNLC_C_OUT 1
`define PNLC_C_ACK 2
`define PNLC_C_FOL 3
`define PNLC_F_VSET 16'h0000
`define PNLC_F_SEL 2'h0
`define PNLC_F_RANGE 1'b1
`define PNLC_F_FAST 1'b0
`define PNLC_F_LOCK 1'b0
`define PNLC_F_ADDR 5'h01
`define PNLC_F_BAUD 3'h3
`define PNLC_R_SRE 8'h00
`define PNLC_R_ACK 1'b1
`define PNLC_R_FOL 1'b1
`define PNLC_STEP_FINE 16'h0001
`define PNLC_STEP_COARSE 16'h0064
`define PNLC_VMAX 16'hea60
`define PNLC_CLK_MHZ 125
`define PNLC_TRIP_MS 1500
`define PNLC_UNLOCK_MS 500
`define PNLC_BLINK_MS 250
`define PNLC_FAST_MS 50
`define PNLC_CYC_MAX(ms) ((ms) * `PNLC_CLK_MHZ * 1000)
`endif

// >>> core/pnlc_pkg.sv
// Types shared by the panel control and its bench.
package pnlc_pkg;
  typedef logic [2:0][15:0] pnlc_vset_t;
  typedef logic [2:0][16:0] pnlc_curr_t;
  typedef enum logic [1:0] {
    PNLC_OFF = 2'b00,
    PNLC_ON = 2'b01,
    PNLC_TRIP = 2'b11
  } pnlc_out_e;
  typedef struct packed {
    pnlc_vset_t vset;
    logic [1:0] sel;
    logic range_hi;
    logic fast;
    logic lock;
    logic [4:0] addr;
    logic [2:0] baud;
  } pnlc_backup_s;
endpackage

// >>> core/pnlc_top.sv
// Front-panel control of a three-channel voltage source with an AXI4-Lite register slave.
// How it works
// - each output key press toggles output; lamp lit while on. The code ignores the output key while remote.
// - output lamp stays continuously lit while output is on.
// - any channel over-range for 1.5 s continuously trips and cuts output.
// - ammeter shows dash pattern while current exceeds the limit.
// - after a trip, show tripping channel and flash the output lamp.
// - output key press during a trip clears it.
// - ammeter shows selected channel current; voltage display its setting.
// - channel picker key steps the selected channel.
// - range key toggles channel-1 range only when channel 1 selected.
// - knob adjusts selected voltage; faster turning gives larger steps.
// - return key while remote lamp lit gives control to the panel.
// - modifier plus return sets key lock; only output key then works.
// - lock releases only after modifier plus return held 0.5 s.
// - modifier plus picker toggles fast sampling and its lamp.
// - fast sampling presents the reading with five-digit resolution.
// - power-on dash display during init never starts a trip.
// - picker held at power-on restores factory settings.
// - every power-on sets output off, local, trip clear, defaults.
// - backed settings survive power-off; factory values given.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "pnlc_regs.svh"
module pnlc_top #(
  parameter int TRIP_CYC = `PNLC_CYC_MAX(`PNLC_TRIP_MS),
  parameter int UNLOCK_CYC = `PNLC_CYC_MAX(`PNLC_UNLOCK_MS),
  parameter int BLINK_CYC = `PNLC_CYC_MAX(`PNLC_BLINK_MS),
  parameter int FAST_CYC = `PNLC_CYC_MAX(`PNLC_FAST_MS)
) (
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  input wire logic I_KEY_OUT,
  input wire logic I_KEY_RANGE,
  input wire logic I_KEY_PICK,
  input wire logic I_KEY_RET,
  input wire logic I_KEY_MOD,
  input wire logic I_KNOB_TICK,
  input wire logic I_KNOB_CW,
  input wire logic I_INIT_BUSY,
  input wire logic [2:0] I_OVER_RANGE,
  input wire pnlc_pkg::pnlc_curr_t I_CURR,
  input wire pnlc_pkg::pnlc_backup_s I_BACKUP,
  output logic O_OUT_EN,
  output logic O_OUT_LAMP,
  output logic O_TRIP,
  output logic [1:0] O_TRIP_CH,
  output logic [1:0] O_SEL,
  output logic O_RANGE_HI,
  output logic O_FAST_LAMP,
  output logic O_LOCK_LAMP,
  output logic O_REMOTE_LAMP,
  output logic O_AMM_DASH,
  output logic [16:0] O_AMM_VAL,
  output logic [15:0] O_VSET_DISP,
  output pnlc_pkg::pnlc_vset_t O_VSET,
  output pnlc_pkg::pnlc_backup_s O_BACKUP,
  output logic O_ACK_EN,
  output logic O_FOLLOW,
  output logic [7:0] O_SRE,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY
);
  import pnlc_pkg::*;

  if (TRIP_CYC < 2 || UNLOCK_CYC < 2 || BLINK_CYC < 1 || FAST_CYC < 1) begin
    $error("pnlc_top: timing counts too small");
  end

  localparam pnlc_backup_s FACT = '{vset: {3{`PNLC_F_VSET}}, sel: `PNLC_F_SEL,
    range_hi: `PNLC_F_RANGE, fast: `PNLC_F_FAST, lock: `PNLC_F_LOCK,
    addr: `PNLC_F_ADDR, baud: `PNLC_F_BAUD};

  // Byte-lane merge of a bus write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Add or subtract a step, held inside zero and full scale.
  function automatic logic [15:0] nudge(input logic [15:0] v, input logic [15:0] s,
                                        input logic up);
    logic [16:0] t;
    t = 17'h00000;
    if (up) begin
      t = {1'b0, v} + {1'b0, s};
      return (t > {1'b0, `PNLC_VMAX}) ? `PNLC_VMAX : t[15:0];
    end
    return (v < s) ? 16'h0000 : v - s;
  endfunction

  logic boot_r, rem_r, lock_r, range_r, fast_r, blink_r, ack_r, fol_r, dash_r;
  logic [1:0] sel_r, trip_ch_r;
  logic [4:0] addr_r;
  logic [2:0] baud_r;
  logic [7:0] sre_r;
  logic [16:0] amm_r;
  pnlc_vset_t vset_r;
  pnlc_out_e state_r;
  logic [31:0] ovr_cnt_r, rel_cnt_r, blink_cnt_r, gap_r;
  logic [4:0] key_q_r;
  pnlc_backup_s boot_src;
  logic p_out, p_rng, p_pick, p_ret, panel_ok, out_cmd, trip_fire, over;
  logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r, rd_word, vset_m, sre_m, cfg_m;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r, wr_ch;
  logic wr_go, wr_map, rd_map, ctrl_wr;

  assign boot_src = I_KEY_PICK ? FACT : I_BACKUP;

  // Key press edges; locked and remote states gate picker, range and knob; remote also gates the output key.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      key_q_r <= 5'h1f;
    end else begin
      key_q_r <= {I_KEY_OUT, I_KEY_RANGE, I_KEY_PICK, I_KEY_RET, I_KEY_MOD};
    end
  end
  assign p_out = I_KEY_OUT & ~key_q_r[4] & ~boot_r;
  assign p_rng = I_KEY_RANGE & ~key_q_r[3] & ~boot_r;
  assign p_pick = I_KEY_PICK & ~key_q_r[2] & ~boot_r;
  assign p_ret = I_KEY_RET & ~key_q_r[1] & ~boot_r;
  assign panel_ok = ~rem_r & ~lock_r;
  assign over = |I_OVER_RANGE;

  // Power-on load of backed settings, the single boot cycle.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
    end
  end

  assign out_cmd = (p_out & ~rem_r) | ctrl_wr & w_data_r[`PNLC_C_OUT];
  assign trip_fire = (state_r == PNLC_ON) & over & ~I_INIT_BUSY
                     & (ovr_cnt_r == TRIP_CYC - 1);

  // Output state: off, on, tripped; power-on always starts off.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_r <= PNLC_OFF;
    end else begin
      case (state_r)
        PNLC_OFF: begin
          if (out_cmd) begin
            state_r <= PNLC_ON;
          end
        end
        PNLC_ON: begin
          if (out_cmd) begin
            state_r <= PNLC_OFF;
          end else if (trip_fire) begin
            state_r <= PNLC_TRIP;
          end
        end
        PNLC_TRIP: begin
          if (out_cmd) begin
            state_r <= PNLC_OFF;
          end
        end
        default: begin
          state_r <= PNLC_OFF;
        end
      endcase
    end
  end

  // restartable over-range timer; held clear during init.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ovr_cnt_r <= 32'h0;
    end else if (I_INIT_BUSY || !over || state_r != PNLC_ON) begin
      ovr_cnt_r <= 32'h0;
    end else if (ovr_cnt_r != TRIP_CYC - 1) begin
      ovr_cnt_r <= ovr_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      trip_ch_r <= 2'h0;
    end else if (trip_fire) begin
      trip_ch_r <= I_OVER_RANGE[0] ? 2'h0 : (I_OVER_RANGE[1] ? 2'h1 : 2'h2);
    end
  end

  // Free-running flash clock for the tripped lamp.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b0;
    end else if (blink_cnt_r == BLINK_CYC - 1) begin
      blink_cnt_r <= 32'h0;
      blink_r <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  // channel step; channel-1 range; sampling toggle.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sel_r <= `PNLC_F_SEL;
      range_r <= `PNLC_F_RANGE;
      fast_r <= `PNLC_F_FAST;
    end else if (boot_r) begin
      sel_r <= boot_src.sel;
      range_r <= boot_src.range_hi;
      fast_r <= boot_src.fast;
    end else if (panel_ok) begin
      if (p_pick && !I_KEY_MOD) begin
        sel_r <= (sel_r == 2'h2) ? 2'h0 : sel_r + 2'h1;
      end
      if (p_pick && I_KEY_MOD) begin
        fast_r <= ~fast_r;
      end
      if (p_rng && sel_r == 2'h0) begin
        range_r <= ~range_r;
      end
    end
  end

  // knob speed: cycles since the previous detent.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      gap_r <= 32'h0;
    end else if (I_KNOB_TICK) begin
      gap_r <= 32'h0;
    end else if (gap_r != FAST_CYC) begin
      gap_r <= gap_r + 32'h1;
    end
  end

  // Voltage settings from the knob while the panel has control, or from the bus at any time.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      vset_r <= {3{`PNLC_F_VSET}};
    end else if (boot_r) begin
      vset_r <= boot_src.vset;
    end else if (wr_go && wr_map && aw_addr_r >= `PNLC_A_VSET0 && aw_addr_r <= `PNLC_A_VSET2) begin
      vset_r[wr_ch] <= (vset_m > {16'h0, `PNLC_VMAX}) ? `PNLC_VMAX : vset_m[15:0];
    end else if (panel_ok && I_KNOB_TICK) begin
      vset_r[sel_r] <= nudge(vset_r[sel_r], (gap_r < FAST_CYC) ? `PNLC_STEP_COARSE :
                             `PNLC_STEP_FINE, I_KNOB_CW);
    end
  end

  // lock set; held release; power-on load.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      lock_r <= `PNLC_F_LOCK;
      rel_cnt_r <= 32'h0;
    end else if (boot_r) begin
      lock_r <= boot_src.lock;
      rel_cnt_r <= 32'h0;
    end else if (!lock_r) begin
      rel_cnt_r <= 32'h0;
      if (p_ret && I_KEY_MOD && !rem_r) begin
        lock_r <= 1'b1;
      end
    end else if (!(I_KEY_RET && I_KEY_MOD)) begin
      rel_cnt_r <= 32'h0;
    end else if (rel_cnt_r == UNLOCK_CYC - 1) begin
      lock_r <= 1'b0;
      rel_cnt_r <= 32'h0;
    end else begin
      rel_cnt_r <= rel_cnt_r + 32'h1;
    end
  end

  // power-on remote state; bus write or return key moves it.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rem_r <= 1'b0;
      ack_r <= `PNLC_R_ACK;
      fol_r <= `PNLC_R_FOL;
    end else if (ctrl_wr) begin
      rem_r <= w_data_r[`PNLC_C_REM];
      ack_r <= w_data_r[`PNLC_C_ACK];
      fol_r <= w_data_r[`PNLC_C_FOL];
    end else if (rem_r && !lock_r && p_ret && !I_KEY_MOD) begin
      rem_r <= 1'b0;
    end
  end

  // Request enable and interface settings written over the bus.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sre_r <= `PNLC_R_SRE;
      addr_r <= `PNLC_F_ADDR;
      baud_r <= `PNLC_F_BAUD;
    end else if (boot_r) begin
      addr_r <= boot_src.addr;
      baud_r <= boot_src.baud;
    end else if (wr_go && aw_addr_r == `PNLC_A_SRE) begin
      sre_r <= sre_m[7:0];
    end else if (wr_go && aw_addr_r == `PNLC_A_CFG) begin
      addr_r <= cfg_m[4:0];
      baud_r <= cfg_m[10:8];
    end
  end

  // dash on over-range; selected current; fine digit.
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      dash_r <= 1'b1;
      amm_r <= 17'h0;
    end else begin
      dash_r <= over | I_INIT_BUSY;
      amm_r <= fast_r ? I_CURR[sel_r] : I_CURR[sel_r] / 17'd10;
    end
  end

  // Panel and analog-side outputs.
  // lamp lit while on; flashing when tripped.
  assign O_OUT_LAMP = (state_r == PNLC_ON) | ((state_r == PNLC_TRIP) & blink_r);
  assign O_OUT_EN = (state_r == PNLC_ON);
  assign O_TRIP = (state_r == PNLC_TRIP);
  assign O_TRIP_CH = trip_ch_r;
  assign O_SEL = sel_r;
  assign O_RANGE_HI = range_r;
  assign O_FAST_LAMP = fast_r;
  assign O_LOCK_LAMP = lock_r;
  assign O_REMOTE_LAMP = rem_r;
  assign O_AMM_DASH = dash_r;
  assign O_AMM_VAL = amm_r;
  assign O_VSET_DISP = vset_r[sel_r];
  assign O_VSET = vset_r;
  // backed settings leave for battery storage.
  assign O_BACKUP = '{vset: vset_r, sel: sel_r, range_hi: range_r, fast: fast_r,
                      lock: lock_r, addr: addr_r, baud: baud_r};
  assign O_ACK_EN = ack_r;
  assign O_FOLLOW = fol_r;
  assign O_SRE = sre_r;

  // Write channel: address and data taken in either order, then committed.
  assign wr_go = aw_have_r & w_have_r & ~bvalid_r;
  assign wr_map = aw_addr_r >= `PNLC_A_CTRL && aw_addr_r <= `PNLC_A_CFG &&
                  aw_addr_r[1:0] == 2'h0;
  assign ctrl_wr = wr_go & (aw_addr_r == `PNLC_A_CTRL) & w_strb_r[0];
  // Held bus word merged into each stored word; the voltage index wraps so 0x10 is channel 3.
  assign wr_ch = aw_addr_r[3:2] - 2'h2;
  assign vset_m = merge({16'h0, vset_r[wr_ch]}, w_data_r, w_strb_r);
  assign sre_m = merge({24'h0, sre_r}, w_data_r, w_strb_r);
  assign cfg_m = merge({21'h0, baud_r, 3'h0, addr_r}, w_data_r, w_strb_r);
  assign O_AWREADY = ~aw_have_r & ~bvalid_r;
  assign O_WREADY = ~w_have_r & ~bvalid_r;
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_have_r <= 1'b1;
        w_data_r <= I_WDATA;
        w_strb_r <= I_WSTRB;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_map ? 2'h0 : 2'h2;
      end else if (bvalid_r && I_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign O_BVALID = bvalid_r;
  assign O_BRESP = bresp_r;

  // Read decode; status is read-only, unmapped words answer with an error.
  always_comb begin
    rd_word = 32'h0;
    rd_map = 1'b1;
    case (I_ARADDR)
      `PNLC_A_STATUS: rd_word = {20'h0, dash_r, I_INIT_BUSY, rem_r, lock_r, fast_r,
                                 range_r, sel_r, trip_ch_r, state_r};
      `PNLC_A_CTRL: rd_word = {28'h0, fol_r, ack_r, O_OUT_EN, rem_r};
      `PNLC_A_VSET0: rd_word = {16'h0, vset_r[0]};
      `PNLC_A_VSET1: rd_word = {16'h0, vset_r[1]};
      `PNLC_A_VSET2: rd_word = {16'h0, vset_r[2]};
      `PNLC_A_SRE: rd_word = {24'h0, sre_r};
      `PNLC_A_CFG: rd_word = {21'h0, baud_r, 3'h0, addr_r};
      default: rd_map = 1'b0;
    endcase
  end
  assign O_ARREADY = ~rvalid_r;
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else if (I_ARVALID && O_ARREADY) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_map ? 2'h0 : 2'h2;
    end else if (rvalid_r && I_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end
  assign O_RVALID = rvalid_r;
  assign O_RDATA = rdata_r;
  assign O_RRESP = rresp_r;

  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_ARST_N);

  sequence s_unlock_hold;
    lock_r && I_KEY_RET && I_KEY_MOD && rel_cnt_r == UNLOCK_CYC - 1;
  endsequence
  sequence s_trip_due;
    state_r == PNLC_ON && over && !I_INIT_BUSY && ovr_cnt_r == TRIP_CYC - 1 && !out_cmd;
  endsequence

  property p_toggle_on;
    p_out && !rem_r && state_r == PNLC_OFF && !boot_r |=> state_r == PNLC_ON;
  endproperty
  a_toggle_on: assert property (p_toggle_on) else $error("output key did not turn on");
  property p_lamp_on;
    state_r == PNLC_ON |-> O_OUT_LAMP && O_OUT_EN;
  endproperty
  a_lamp_on: assert property (p_lamp_on) else $error("lamp dark while on");
  property p_trip;
    s_trip_due |=> state_r == PNLC_TRIP && !O_OUT_EN;
  endproperty
  a_trip: assert property (p_trip) else $error("trip missed after timeout");
  property p_dash;
    over |=> O_AMM_DASH;
  endproperty
  a_dash: assert property (p_dash) else $error("no dash on over-range");
  property p_flash;
    state_r == PNLC_TRIP |-> O_OUT_LAMP == blink_r;
  endproperty
  a_flash: assert property (p_flash) else $error("trip lamp not flashing");
  property p_clear;
    state_r == PNLC_TRIP && out_cmd |=> state_r == PNLC_OFF;
  endproperty
  a_clear: assert property (p_clear) else $error("trip not cleared");
  property p_range_ignored;
    p_rng && sel_r != 2'h0 && !boot_r |=> $stable(range_r);
  endproperty
  a_range_ignored: assert property (p_range_ignored) else $error("range moved");
  property p_unlock;
    s_unlock_hold |=> !lock_r;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock not released");
  property p_no_early_unlock;
    $fell(lock_r) |-> $past(rel_cnt_r) == UNLOCK_CYC - 1;
  endproperty
  a_no_early_unlock: assert property (p_no_early_unlock) else $error("early unlock");
  property p_init_no_trip;
    I_INIT_BUSY |=> ovr_cnt_r == 32'h0 && state_r != PNLC_TRIP || $past(state_r) == PNLC_TRIP;
  endproperty
  a_init_no_trip: assert property (p_init_no_trip) else $error("init started a trip");
  property p_restart;
    !over |=> ovr_cnt_r == 32'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted");
endmodule

// >>> sim/pnlc_panel_model.sv
// Behavioural model of the front-panel keys and the voltage knob.
`timescale 1ns/1ps
module pnlc_panel_model (
  input wire logic i_clk,
  output logic [4:0] o_keys,
  output logic o_tick,
  output logic o_cw
);
  // Keys start released and the knob idle.
  initial begin
    o_keys = 5'h00;
    o_tick = 1'b0;
    o_cw = 1'b0;
  end
  // Holds one key for some cycles, then lets the press logic settle.
  task automatic press(input int k, input int hold);
    o_keys[k] <= 1'b1;
    repeat (hold) @(posedge i_clk);
    o_keys[k] <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  // Sets a key as a level, used for the modifier and power-on gestures.
  task automatic set(input int k, input logic v);
    o_keys[k] <= v;
    @(posedge i_clk);
  endtask
  // Gives one detent after an idle gap, so the gap sets the turn speed.
  task automatic turn(input logic cw, input int gap);
    repeat (gap) @(posedge i_clk);
    o_cw <= cw;
    o_tick <= 1'b1;
    @(posedge i_clk);
    o_tick <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
endmodule

// >>> sim/panel_output_control_tb_top.sv
// Self-checking bench for the panel output control.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module panel_output_control_tb_top;
  import pnlc_pkg::*;
  logic clk, rst_n, ib, awv, wv, brdy, arv, rrdy, tick, cw, en, lamp, trip, rng, fast, lock;
  logic rem, dash, awr, wr_r, bv, arr, rv, ack, fol;
  logic [1:0] tch, sel, br, rr;
  logic [2:0] over;
  logic [4:0] keys;
  logic [7:0] awa, ara, sre;
  logic [15:0] vd;
  logic [16:0] amm;
  logic [31:0] wd, rdat, rd;
  pnlc_curr_t curr;
  pnlc_backup_s bk, bko;
  pnlc_vset_t vs;
  int err_count, num_checks, hi;
  pnlc_panel_model pm (.i_clk(clk), .o_keys(keys), .o_tick(tick), .o_cw(cw));
  pnlc_top #(.TRIP_CYC(20), .UNLOCK_CYC(10), .BLINK_CYC(3), .FAST_CYC(5)) DUT (
    .I_REF_CLK(clk), .I_ARST_N(rst_n), .I_KEY_OUT(keys[0]), .I_KEY_RANGE(keys[1]),
    .I_KEY_PICK(keys[2]), .I_KEY_RET(keys[3]), .I_KEY_MOD(keys[4]), .I_KNOB_TICK(tick),
    .I_KNOB_CW(cw), .I_INIT_BUSY(ib), .I_OVER_RANGE(over), .I_CURR(curr), .I_BACKUP(bk),
    .O_OUT_EN(en), .O_OUT_LAMP(lamp), .O_TRIP(trip), .O_TRIP_CH(tch), .O_SEL(sel),
    .O_RANGE_HI(rng), .O_FAST_LAMP(fast), .O_LOCK_LAMP(lock), .O_REMOTE_LAMP(rem),
    .O_AMM_DASH(dash), .O_AMM_VAL(amm), .O_VSET_DISP(vd), .O_VSET(vs), .O_BACKUP(bko),
    .O_ACK_EN(ack), .O_FOLLOW(fol), .O_SRE(sre), .I_AWADDR(awa), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wr_r),
    .O_BRESP(br), .O_BVALID(bv), .I_BREADY(brdy), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rrdy));
  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Bus write: address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv) break;
    end
    brdy <= 1'b0;
    if (n == 40) begin
      err_count++;
      summarize();
    end
    `CHK(br, er)
  endtask
  // Bus read: the answer is taken at the edge where valid is seen.
  task automatic rdw(input logic [7:0] a, input logic [1:0] er);
    int n;
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) break;
    end
    rrdy <= 1'b0;
    rd = rdat;
    if (n == 40) begin
      err_count++;
      summarize();
    end
    `CHK(rr, er)
  endtask
  // Main sequence of scenarios.
  initial begin
    {rst_n, awv, wv, brdy, arv, rrdy, over, awa, ara, wd} = '0;
    ib = 1'b1;
    curr[0] = 17'h004d2;
    curr[1] = 17'h00190;
    curr[2] = 17'h01388;
    bk = '0;
    bk.sel = 2'h1;
    bk.range_hi = 1'b1;
    bk.vset[1] = 16'h0100;
    repeat (10) @(posedge clk);
    `CHK(dash, 1'b1)
    `CHK(en, 1'b0)
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(sel, 2'h1)
    `CHK(vs[1], 16'h0100)
    `CHK({ack, fol, sre, rem, trip}, 12'hc00)
    // Output on while initialisation runs with an over-range: no trip.
    pm.press(0, 2);
    over <= 3'b001;
    repeat (30) @(posedge clk);
    `CHK(trip, 1'b0)
    `CHK(en, 1'b1)
    over <= 3'b000;
    ib <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(dash, 1'b0)
    repeat (6) begin
      @(posedge clk);
      `CHK(lamp, 1'b1)
    end
    // Interrupted over-range restarts the timer, a continuous one trips.
    over <= 3'b010;
    repeat (10) @(posedge clk);
    over <= 3'b000;
    @(posedge clk);
    over <= 3'b010;
    repeat (12) @(posedge clk);
    `CHK(trip, 1'b0)
    `CHK(dash, 1'b1)
    repeat (15) @(posedge clk);
    `CHK({trip, en}, 2'b10)
    `CHK(tch, 2'h1)
    hi = 0;
    repeat (12) begin
      @(posedge clk);
      hi += (lamp === 1'b1);
    end
    `CHK(hi > 0 && hi < 12, 1'b1)
    over <= 3'b000;
    pm.press(0, 2);
    `CHK({trip, en}, 2'b00)
    // Picker held through power-on restores factory settings.
    rst_n <= 1'b0;
    pm.set(2, 1'b1);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    pm.set(2, 1'b0);
    `CHK({sel, rng, vs}, {2'h0, 1'b1, 48'h0})
    // Register access, refusals included.
    wr(8'h0c, 32'h00001234, 2'b00);
    `CHK(vs[1], 16'h1234)
    rdw(8'h0c, 2'b00);
    `CHK(rd, 32'h00001234)
    wr(8'h40, 32'h00000001, 2'b10);
    wr(8'h00, 32'h00000001, 2'b10);
    wr(8'h14, 32'h0000005a, 2'b00);
    `CHK(sre, 8'h5a)
    rdw(8'h44, 2'b10);
    `CHK(rd, 32'h00000000)
    // Step through channels; the displays follow the selection.
    for (int i = 1; i < 4; i++) begin
      pm.press(2, 2);
      `CHK(sel, 2'(i % 3))
      `CHK(amm, curr[i % 3] / 17'd10)
      `CHK(vd, (i % 3 == 1) ? 16'h1234 : 16'h0000)
    end
    pm.press(1, 2);
    `CHK(rng, 1'b0)
    pm.press(2, 2);
    pm.press(1, 2);
    `CHK(rng, 1'b0)
    pm.press(2, 2);
    pm.press(2, 2);
    // Slow then fast detents on channel one.
    pm.turn(1'b1, 10);
    `CHK(vs[0], 16'h0001)
    pm.turn(1'b1, 0);
    `CHK(vs[0], 16'h0065)
    pm.turn(1'b0, 10);
    `CHK(vs[0], 16'h0064)
    // Modifier plus picker toggles fast sampling.
    pm.set(4, 1'b1);
    pm.press(2, 2);
    `CHK({fast, sel}, 3'b100)
    `CHK(amm, curr[0])
    pm.press(2, 2);
    pm.set(4, 1'b0);
    `CHK(fast, 1'b0)
    // Key lock: only the output key works; a short hold does not unlock.
    pm.set(4, 1'b1);
    pm.press(3, 2);
    pm.set(4, 1'b0);
    `CHK(lock, 1'b1)
    pm.press(2, 2);
    `CHK(sel, 2'h0)
    pm.press(0, 2);
    `CHK(en, 1'b1)
    pm.set(4, 1'b1);
    pm.press(3, 4);
    `CHK(lock, 1'b1)
    pm.press(3, 15);
    pm.set(4, 1'b0);
    `CHK(lock, 1'b0)
    // Remote mode ignores the picker; the return key gives control back.
    wr(8'h04, 32'h0000000d, 2'b00);
    `CHK(rem, 1'b1)
    pm.press(2, 2);
    `CHK(sel, 2'h0)
    pm.press(3, 2);
    `CHK(rem, 1'b0)
    // Interface settings, then the whole battery image of the backed settings.
    wr(8'h18, 32'h00000205, 2'b00);
    `CHK(bko, {16'h0000, 16'h1234, 16'h0064, 2'h0, 1'b0, 1'b0, 1'b0, 5'h05, 3'h2})
    summarize();
  end
endmodule
